/* rtl/dual_pot_pkg.sv */
// Shared constants and types of the dual potentiometer command decoder
package dual_pot_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int PROG_TIME_MS  = 10;
   // Longest time, so the division rounds down
   localparam int PROG_CYCLES   = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PCNT_W        = 17;
   // ==========================================================
   // Byte fields
   localparam int TYPE_MSB  = 7;
   localparam int STRAP_MSB = 3;
   localparam int OPC_MSB   = 7;
   localparam int SEL_MSB   = 3;
   localparam int POT_MSB   = 1;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Device type nibble; the value is arbitrary
   localparam logic [3:0] DEV_TYPE = 4'hA;
   // ==========================================================
   // Opcodes
   localparam logic [3:0] OP_RD_WIPER  = 4'h9;
   localparam logic [3:0] OP_WR_WIPER  = 4'hA;
   localparam logic [3:0] OP_RD_STORED = 4'hB;
   localparam logic [3:0] OP_WR_STORED = 4'hC;
   localparam logic [3:0] OP_COPY_S2W  = 4'hD;
   localparam logic [3:0] OP_COPY_W2S  = 4'hE;
   localparam logic [3:0] OP_GANG_S2W  = 4'h1;
   localparam logic [3:0] OP_GANG_W2S  = 4'h8;
   localparam logic [3:0] OP_STEP      = 4'h2;
   localparam logic [1:0] SEL_ZERO     = 2'h0;
   localparam logic [1:0] POT_ZERO     = 2'h0;
   // ==========================================================
   // Register values
   localparam logic [7:0]   WIPER_MIN    = 8'h00;
   localparam logic [7:0]   WIPER_MAX    = 8'hFF;
   localparam logic [7:0]   WIPER_RST    = 8'h00;
   localparam logic [7:0]   STORED_INIT  = 8'h80;
   localparam logic [2:0]   STORED0_POT0 = 3'h0;
   localparam logic [2:0]   STORED0_POT1 = 3'h4;
   localparam logic [255:0] TAP_ONE      = 256'h1;
   // ==========================================================
   // Command sequence states
   typedef enum logic [3:0] {
      ST_RECALL, ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INSTR, ST_INSTR_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_STEP, ST_IGNORE,
      ST_PROG
   } seq_state_t;
endpackage

/* rtl/dual_pot_command_decoder.sv */
// Two-wire command decoder with wiper and stored-setting registers
`timescale 1ns/10ps
// How it works
// R1: Address high nibble must be type code
// R2: Address low nibble must match straps
// R3: Instruction: opcode, setting select, pot select
// R4: Select 00 is setting zero, 01 one
// R5: Select 10 is setting two, 11 three
// R6: Two wipers, each one-hot over 256 taps
// R7: Power-up loads wipers from setting zero
// R8: Four stored settings per pot, read/write
// R9: Stored-setting programming ends within 10 ms
// R10: Opcode 1001 reads the wiper register
// R11: Opcode 1010 writes the wiper register
// R12: Opcode 1011 reads a stored setting
// R13: Opcode 1100 programs a stored setting
// R14: Opcode 1101 copies setting into wiper
// R15: Opcode 1110 copies wiper into setting
// R16: Opcode 0001 gang copies settings to wipers
// R17: Opcode 1000 gang copies wipers to settings
// R18: Opcode 0010 arms wiper stepping
// R19: Reads/writes three bytes, copies two bytes
// R20: Wiper copy effects wait write cycle
// R21: After stepping ack, master clocks steps
// R22: Clock high with data high steps up
// R23: Stepping saturates at 0 and 255
// R24: Unlisted instruction changes no register
// R25: No address ack while programming
// R26: Write protect withholds data ack, programming
// R27: Acknowledge address and each written byte
// R28: Programming starts only at stop
module dual_pot_command_decoder #(
   parameter int PROG_CYCLES = dual_pot_pkg::PROG_CYCLES
) (
   // Clock and reset
   input  wire logic         I_CLK,
   input  wire logic         I_RST,
   // Two-wire link
   input  wire logic         I_SCL,
   input  wire logic         I_SDA,
   output logic              O_SDA,
   output logic              O_SDA_OE_N,
   // Straps and protection
   input  wire logic [3:0]   I_STRAP_ADDRESS_BITS,
   input  wire logic         I_WP_N,
   // Wiper state and programming busy
   output logic [7:0]        O_WIPER0_POS,
   output logic [7:0]        O_WIPER1_POS,
   output logic [255:0]      O_TAP0,
   output logic [255:0]      O_TAP1,
   output logic              O_PROG_BUSY
);
   // ==========================================================
   // State
   typedef struct packed {
      dual_pot_pkg::seq_state_t    st;
      logic                        scl_m;
      logic                        scl_s;
      logic                        scl_d;
      logic                        sda_m;
      logic                        sda_s;
      logic                        sda_d;
      logic [3:0]                  strap_m;
      logic [3:0]                  strap_s;
      logic                        wp_n_m;
      logic                        wp_n_s;
      logic [3:0]                  cnt;
      logic [7:0]                  sh;
      logic [7:0]                  rbyte;
      logic [7:0]                  instr;
      logic [7:0]                  pdata;
      logic                        pend;
      logic                        mack;
      logic                        sda_oe_n;
      logic                        sda_o;
      logic                        busy;
      logic [dual_pot_pkg::PCNT_W-1:0] pcnt;
      logic [1:0][7:0]             wiper;
      // R8: four stored bytes per pot
      logic [7:0][7:0]             stored;
      logic [255:0]                tap0;
      logic [255:0]                tap1;
   } state_t;

   state_t r;
   state_t r_nxt;
   logic   scl_rise;
   logic   scl_fall;
   logic   start;
   logic   stop;
   logic [3:0] opc;
   logic [1:0] sel;
   logic [1:0] pot;
   logic [2:0] idx;
   logic       instr_ok;
   logic       addr_ok;

   // Only second and third stages are looked at, never the first
   assign scl_rise = r.scl_s & ~r.scl_d;
   assign scl_fall = ~r.scl_s & r.scl_d;
   assign start    = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
   assign stop     = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
   // R3: instruction field split
   assign opc = r.instr[dual_pot_pkg::OPC_MSB -: 4];
   assign sel = r.instr[dual_pot_pkg::SEL_MSB -: 2];
   assign pot = r.instr[dual_pot_pkg::POT_MSB -: 2];
   // R4: R5: setting select indexes four per pot
   assign idx = {pot[0], sel};
   // R1: R2: type code and strap compare
   assign addr_ok = (r.sh[dual_pot_pkg::TYPE_MSB -: 4] == dual_pot_pkg::DEV_TYPE) &&
                    (r.sh[dual_pot_pkg::STRAP_MSB -: 4] == r.strap_s);

   // R24: only the nine listed forms are legal
   always_comb begin
      unique case (opc)
         dual_pot_pkg::OP_RD_WIPER, dual_pot_pkg::OP_WR_WIPER, dual_pot_pkg::OP_STEP:
            instr_ok = (sel == dual_pot_pkg::SEL_ZERO) && !pot[1];
         dual_pot_pkg::OP_RD_STORED, dual_pot_pkg::OP_WR_STORED,
         dual_pot_pkg::OP_COPY_S2W, dual_pot_pkg::OP_COPY_W2S:
            instr_ok = !pot[1];
         dual_pot_pkg::OP_GANG_S2W, dual_pot_pkg::OP_GANG_W2S:
            instr_ok = (pot == dual_pot_pkg::POT_ZERO);
         default:
            instr_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      r_nxt = r;
      r_nxt.scl_m   = I_SCL;
      r_nxt.scl_s   = r.scl_m;
      r_nxt.scl_d   = r.scl_s;
      r_nxt.sda_m   = I_SDA;
      r_nxt.sda_s   = r.sda_m;
      r_nxt.sda_d   = r.sda_s;
      r_nxt.strap_m = I_STRAP_ADDRESS_BITS;
      r_nxt.strap_s = r.strap_m;
      r_nxt.wp_n_m  = I_WP_N;
      r_nxt.wp_n_s  = r.wp_n_m;
      // R6: one tap switch closed per wiper
      r_nxt.tap0 = dual_pot_pkg::TAP_ONE << r.wiper[0];
      r_nxt.tap1 = dual_pot_pkg::TAP_ONE << r.wiper[1];
      unique case (r.st)
         dual_pot_pkg::ST_RECALL: begin
            // R7: recall setting zero into wipers
            r_nxt.wiper[0] = r.stored[dual_pot_pkg::STORED0_POT0];
            r_nxt.wiper[1] = r.stored[dual_pot_pkg::STORED0_POT1];
            r_nxt.st       = dual_pot_pkg::ST_IDLE;
         end
         dual_pot_pkg::ST_IDLE, dual_pot_pkg::ST_IGNORE: begin
         end
         dual_pot_pkg::ST_ADDR, dual_pot_pkg::ST_INSTR, dual_pot_pkg::ST_WDATA: begin
            if (scl_rise) begin
               r_nxt.sh  = {r.sh[6:0], r.sda_s};
               r_nxt.cnt = r.cnt + 4'h1;
            end
            if (scl_fall && r.cnt == dual_pot_pkg::BYTE_BITS) begin
               r_nxt.cnt = '0;
               if (r.st == dual_pot_pkg::ST_ADDR) begin
                  // R1: R2: R27: ack only own address
                  r_nxt.sda_oe_n = !addr_ok;
                  r_nxt.st = addr_ok ? dual_pot_pkg::ST_ADDR_ACK : dual_pot_pkg::ST_IGNORE;
               end else if (r.st == dual_pot_pkg::ST_INSTR) begin
                  // R27: instruction byte always acked
                  r_nxt.instr    = r.sh;
                  r_nxt.sda_oe_n = 1'b0;
                  r_nxt.st       = dual_pot_pkg::ST_INSTR_ACK;
               end else begin
                  r_nxt.st       = dual_pot_pkg::ST_WDATA_ACK;
                  r_nxt.sda_oe_n = 1'b0;
                  if (opc == dual_pot_pkg::OP_WR_WIPER) begin
                     // R11: data byte into wiper
                     r_nxt.wiper[pot[0]] = r.sh;
                  end else if (r.wp_n_s) begin
                     // R13: held for programming at stop
                     r_nxt.pend  = 1'b1;
                     r_nxt.pdata = r.sh;
                  end else begin
                     // R26: protected, no ack and no programming
                     r_nxt.sda_oe_n = 1'b1;
                     r_nxt.st       = dual_pot_pkg::ST_IGNORE;
                  end
               end
            end
         end
         dual_pot_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
               r_nxt.sda_oe_n = 1'b1;
               r_nxt.st       = dual_pot_pkg::ST_INSTR;
            end
         end
         dual_pot_pkg::ST_INSTR_ACK: begin
            if (scl_fall) begin
               r_nxt.sda_oe_n = 1'b1;
               r_nxt.st       = dual_pot_pkg::ST_IGNORE;
               if (instr_ok) begin
                  unique case (opc)
                     dual_pot_pkg::OP_RD_WIPER, dual_pot_pkg::OP_RD_STORED: begin
                        // R10: R12: R19: third byte goes out
                        r_nxt.rbyte = (opc == dual_pot_pkg::OP_RD_WIPER) ?
                                      r.wiper[pot[0]] : r.stored[idx];
                        r_nxt.sh    = r_nxt.rbyte;
                        r_nxt.sda_oe_n = r_nxt.rbyte[7];
                        r_nxt.st    = dual_pot_pkg::ST_RDATA;
                     end
                     dual_pot_pkg::OP_WR_WIPER, dual_pot_pkg::OP_WR_STORED:
                        r_nxt.st = dual_pot_pkg::ST_WDATA;
                     // R14: copy setting into wiper, no data
                     dual_pot_pkg::OP_COPY_S2W:
                        r_nxt.wiper[pot[0]] = r.stored[idx];
                     dual_pot_pkg::OP_GANG_S2W: begin
                        // R16: both pots at once
                        r_nxt.wiper[0] = r.stored[{1'b0, sel}];
                        r_nxt.wiper[1] = r.stored[{1'b1, sel}];
                     end
                     // R15: R17: R20: copies wait for stop and write cycle
                     dual_pot_pkg::OP_COPY_W2S, dual_pot_pkg::OP_GANG_W2S:
                        r_nxt.pend = 1'b1;
                     // R18: R21: arm stepping
                     dual_pot_pkg::OP_STEP:
                        r_nxt.st = dual_pot_pkg::ST_STEP;
                     default: begin
                     end
                  endcase
               end
            end
         end
         dual_pot_pkg::ST_WDATA_ACK: begin
            if (scl_fall) begin
               r_nxt.sda_oe_n = 1'b1;
               r_nxt.st       = dual_pot_pkg::ST_IGNORE;
            end
         end
         dual_pot_pkg::ST_RDATA: begin
            if (scl_rise) begin
               r_nxt.cnt = r.cnt + 4'h1;
            end
            if (scl_fall) begin
               if (r.cnt == dual_pot_pkg::BYTE_BITS) begin
                  r_nxt.cnt      = '0;
                  r_nxt.sda_oe_n = 1'b1;
                  r_nxt.st       = dual_pot_pkg::ST_RDATA_ACK;
               end else begin
                  r_nxt.sh       = {r.sh[6:0], 1'b0};
                  r_nxt.sda_oe_n = r.sh[6];
               end
            end
         end
         dual_pot_pkg::ST_RDATA_ACK: begin
            if (scl_rise) begin
               r_nxt.mack = !r.sda_s;
            end
            // Master ack repeats the same register
            if (scl_fall) begin
               if (r.mack) begin
                  r_nxt.sh       = r.rbyte;
                  r_nxt.sda_oe_n = r.rbyte[7];
                  r_nxt.st       = dual_pot_pkg::ST_RDATA;
               end else begin
                  r_nxt.st = dual_pot_pkg::ST_IGNORE;
               end
            end
         end
         dual_pot_pkg::ST_STEP: begin
            // R22: R23: saturating single steps
            if (scl_rise) begin
               if (r.sda_s && r.wiper[pot[0]] != dual_pot_pkg::WIPER_MAX) begin
                  r_nxt.wiper[pot[0]] = r.wiper[pot[0]] + 8'h01;
               end else if (!r.sda_s && r.wiper[pot[0]] != dual_pot_pkg::WIPER_MIN) begin
                  r_nxt.wiper[pot[0]] = r.wiper[pot[0]] - 8'h01;
               end
            end
         end
         dual_pot_pkg::ST_PROG: begin
            // R9: commit when the write cycle count runs out
            if (r.pcnt == '0) begin
               r_nxt.pend = 1'b0;
               r_nxt.st   = dual_pot_pkg::ST_IDLE;
               unique case (opc)
                  dual_pot_pkg::OP_WR_STORED:
                     r_nxt.stored[idx] = r.pdata;
                  dual_pot_pkg::OP_COPY_W2S:
                     r_nxt.stored[idx] = r.wiper[pot[0]];
                  dual_pot_pkg::OP_GANG_W2S: begin
                     r_nxt.stored[{1'b0, sel}] = r.wiper[0];
                     r_nxt.stored[{1'b1, sel}] = r.wiper[1];
                  end
                  default: begin
                  end
               endcase
            end else begin
               r_nxt.pcnt = r.pcnt - 1'b1;
            end
         end
      endcase
      // R25: bus ignored while programming
      if (r.st != dual_pot_pkg::ST_PROG && r.st != dual_pot_pkg::ST_RECALL) begin
         if (start) begin
            // A restart abandons any held programming
            r_nxt.st       = dual_pot_pkg::ST_ADDR;
            r_nxt.cnt      = '0;
            r_nxt.sda_oe_n = 1'b1;
            r_nxt.pend     = 1'b0;
         end else if (stop) begin
            r_nxt.sda_oe_n = 1'b1;
            // R28: R26: programming begins at stop, if unprotected
            if (r.pend && r.wp_n_s) begin
               r_nxt.st   = dual_pot_pkg::ST_PROG;
               r_nxt.pcnt = dual_pot_pkg::PCNT_W'(PROG_CYCLES - 1);
            end else begin
               r_nxt.pend = 1'b0;
               r_nxt.st   = dual_pot_pkg::ST_IDLE;
            end
         end
      end
      // Busy pin straight from a flop, same timing as the state
      r_nxt.busy = (r_nxt.st == dual_pot_pkg::ST_PROG);
   end

   // ==========================================================
   // Registers
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         r          <= '0;
         r.st       <= dual_pot_pkg::ST_RECALL;
         r.scl_m    <= 1'b1;
         r.scl_s    <= 1'b1;
         r.scl_d    <= 1'b1;
         r.sda_m    <= 1'b1;
         r.sda_s    <= 1'b1;
         r.sda_d    <= 1'b1;
         r.wp_n_m   <= 1'b1;
         r.wp_n_s   <= 1'b1;
         r.sda_oe_n <= 1'b1;
         r.wiper    <= {2{dual_pot_pkg::WIPER_RST}};
         // Stand-in for nonvolatile contents at power-up
         r.stored   <= {8{dual_pot_pkg::STORED_INIT}};
         r.tap0     <= dual_pot_pkg::TAP_ONE;
         r.tap1     <= dual_pot_pkg::TAP_ONE;
      end else begin
         r <= r_nxt;
      end
   end

   assign O_SDA        = r.sda_o;
   assign O_SDA_OE_N   = r.sda_oe_n;
   assign O_WIPER0_POS = r.wiper[0];
   assign O_WIPER1_POS = r.wiper[1];
   assign O_TAP0       = r.tap0;
   assign O_TAP1       = r.tap1;
   assign O_PROG_BUSY  = r.busy;

   // ==========================================================
   // Checks
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   sequence addr_byte_done;
      r.st == dual_pot_pkg::ST_ADDR && scl_fall && r.cnt == dual_pot_pkg::BYTE_BITS;
   endsequence
   sequence stop_with_pend;
      stop && r.pend && r.wp_n_s && r.st != dual_pot_pkg::ST_PROG &&
      r.st != dual_pot_pkg::ST_RECALL;
   endsequence

   type_nack_a: assert property ( // R1
      addr_byte_done and (r.sh[7:4] != dual_pot_pkg::DEV_TYPE)
      |=> r.sda_oe_n ##1 r.st != dual_pot_pkg::ST_INSTR)
      else $error("foreign type acked");
   strap_ack_a: assert property ( // R2
      addr_byte_done and addr_ok
      |=> !r.sda_oe_n && r.st == dual_pot_pkg::ST_ADDR_ACK)
      else $error("own address not acked");
   recall_a: assert property ( // R7
      r.st == dual_pot_pkg::ST_RECALL
      |=> r.wiper[0] == $past(r.stored[0]) && r.wiper[1] == $past(r.stored[4]))
      else $error("wiper not recalled");
   tap_decode_a: assert property ( // R6
      r.st != dual_pot_pkg::ST_RECALL
      |=> r.tap0 == (dual_pot_pkg::TAP_ONE << $past(r.wiper[0])))
      else $error("tap decode wrong");
   step_up_a: assert property ( // R22
      r.st == dual_pot_pkg::ST_STEP && scl_rise && r.sda_s &&
      r.wiper[pot[0]] != dual_pot_pkg::WIPER_MAX
      |=> r.wiper[pot[0]] == $past(r.wiper[pot[0]]) + 8'h01)
      else $error("step up missed");
   sat_top_a: assert property ( // R23
      r.st == dual_pot_pkg::ST_STEP && scl_rise && r.sda_s &&
      r.wiper[pot[0]] == dual_pot_pkg::WIPER_MAX
      |=> r.wiper[pot[0]] == dual_pot_pkg::WIPER_MAX)
      else $error("wiper wrapped");
   prog_quiet_a: assert property ( // R25
      r.st == dual_pot_pkg::ST_PROG && r.pcnt != '0
      |=> r.st == dual_pot_pkg::ST_PROG && r.sda_oe_n)
      else $error("bus answered while programming");
   prog_start_a: assert property ( // R28
      stop_with_pend |=> r.st == dual_pot_pkg::ST_PROG ##1 $stable(r.stored))
      else $error("programming not started at stop");
   prog_only_stop_a: assert property ( // R28
      $rose(r.st == dual_pot_pkg::ST_PROG) |-> $past(stop))
      else $error("programming without stop");
   prog_len_a: assert property ( // R9
      r.st == dual_pot_pkg::ST_PROG |-> r.pcnt < PROG_CYCLES)
      else $error("write cycle too long");
   wp_nack_a: assert property ( // R26
      r.st == dual_pot_pkg::ST_WDATA && scl_fall && r.cnt == dual_pot_pkg::BYTE_BITS &&
      opc == dual_pot_pkg::OP_WR_STORED && !r.wp_n_s
      |=> r.sda_oe_n && !r.pend)
      else $error("protected write acked");
endmodule

/* sim/two_wire_master.sv */
// Behavioural two-wire bus master driving the decoder's link pins
`timescale 1ns/10ps
module two_wire_master (
   // Clock
   input  wire logic i_clk,
   // Bus wires
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   // ==========================================
   // Idle bus: both lines released high
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // Every change lands just after a clock edge
   task automatic wait_q(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // ==========================================
   // each frame opens with a start
   task automatic start_c();
      o_sda = 1'b1;
      wait_q(2);
      o_scl = 1'b1;
      wait_q(4);
      o_sda = 1'b0;
      wait_q(4);
      o_scl = 1'b0;
      wait_q(2);
   endtask
   // each frame closes with a stop
   task automatic stop_c();
      o_sda = 1'b0;
      wait_q(2);
      o_scl = 1'b1;
      wait_q(4);
      o_sda = 1'b1;
      wait_q(4);
   endtask
   // one clock pulse, data stable while high
   task automatic bit_x(input logic b, output logic r);
      o_sda = b;
      wait_q(2);
      o_scl = 1'b1;
      wait_q(4);
      r = i_sda;
      o_scl = 1'b0;
      wait_q(2);
   endtask
   // byte MSB first, ninth clock is the ack
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                       output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(mack, a);
      ack = ~a;
   endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the dual potentiometer command decoder
`timescale 1ns/10ps
module tb_top;
   // Short programming window keeps the run brief
   localparam int PC = 200;
   logic         clk, rst, wp_n, sda_o, oe_n, busy, scl, m_sda;
   logic [3:0]   strap;
   logic [7:0]   w0, w1, addr, q;
   logic [255:0] tap0, tap1;
   wire          sda_w;
   integer       seed = 93825;
   int           errors = 0;
   int           comparisons = 0;
   int           cycles = 0;
   int           wiper[2];
   int           stored[8];
   // Pulled-up wire: low when either party pulls
   assign sda_w = m_sda & (oe_n | sda_o);
   dual_pot_command_decoder #(.PROG_CYCLES(PC)) dut_u (.I_CLK(clk), .I_RST(rst), .I_SCL(scl),
      .I_SDA(sda_w), .O_SDA(sda_o), .O_SDA_OE_N(oe_n), .I_STRAP_ADDRESS_BITS(strap),
      .I_WP_N(wp_n), .O_WIPER0_POS(w0), .O_WIPER1_POS(w1), .O_TAP0(tap0), .O_TAP1(tap1),
      .O_PROG_BUSY(busy));
   two_wire_master master_u (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
   // ==========================================
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ==========================================
   task automatic head(input logic [7:0] ins);
      logic a;
      master_u.start_c();
      master_u.xfer(addr, 1'b1, q, a);
      chk("addr ack", 8'h01, {7'h0, a});
      master_u.xfer(ins, 1'b1, q, a);
      chk("instr ack", 8'h01, {7'h0, a});
   endtask
   task automatic wr(input logic [7:0] ins, input logic [7:0] d, input logic ea);
      logic a;
      head(ins);
      master_u.xfer(d, 1'b1, q, a);
      chk("data ack", {7'h0, ea}, {7'h0, a});
      chk("busy before stop", 8'h00, {7'h0, busy});
      master_u.stop_c();
   endtask
   task automatic rd(input logic [7:0] ins, input logic [7:0] ev, input logic rep);
      logic a;
      head(ins);
      if (rep) begin
         master_u.xfer(8'hFF, 1'b0, q, a);
         chk("read before master ack", ev, q);
      end
      master_u.xfer(8'hFF, 1'b1, q, a);
      master_u.stop_c();
   endtask
   task automatic cmd(input logic [7:0] ins);
      head(ins);
      master_u.stop_c();
   endtask
   task automatic prog_wait();
      logic a;
      int   n;
      n = 0;
      master_u.start_c();
      master_u.xfer(addr, 1'b1, q, a);
      chk("busy", 8'h01, {7'h0, busy});
      chk("poll ack", 8'h00, {7'h0, a});
      master_u.stop_c();
      while (busy === 1'b1 && n < PC) begin
         @(posedge clk);
         n++;
      end
      #1;
      chk("busy end", 8'h00, {7'h0, busy});
   endtask
   task automatic compare_all();
      chk("wiper0", wiper[0][7:0], w0);
      chk("wiper1", wiper[1][7:0], w1);
      chk("tap0", 8'h01, {7'h0, tap0 === (256'h1 << wiper[0])});
      chk("tap1", 8'h01, {7'h0, tap1 === (256'h1 << wiper[1])});
      for (int p = 0; p < 2; p++) begin
         rd({dual_pot_pkg::OP_RD_WIPER, 3'h0, p[0]}, wiper[p][7:0], 1'b1);
         chk("read wiper", wiper[p][7:0], q);
      end
      for (int i = 0; i < 8; i++) begin
         rd({dual_pot_pkg::OP_RD_STORED, i[1:0], 1'b0, i[2]}, stored[i][7:0], 1'b0);
         chk("read stored", stored[i][7:0], q);
      end
   endtask
   task automatic step_run(input logic p, input logic [7:0] s, input int ups, input int dns);
      logic r;
      wr({dual_pot_pkg::OP_WR_WIPER, 3'h0, p}, s, 1'b1);
      wiper[p] = s;
      head({dual_pot_pkg::OP_STEP, 3'h0, p});
      repeat (ups) begin
         master_u.bit_x(1'b1, r);
         wiper[p] = (wiper[p] == 255) ? 255 : wiper[p] + 1;
      end
      repeat (dns) begin
         master_u.bit_x(1'b0, r);
         wiper[p] = (wiper[p] == 0) ? 0 : wiper[p] - 1;
      end
      // Stop's own clock rise with data low is one more down step
      wiper[p] = (wiper[p] == 0) ? 0 : wiper[p] - 1;
      master_u.stop_c();
   endtask
   // ==========================================
   initial begin
      int          k;
      logic [7:0]  d;
      logic [3:0]  bad_ops[7];
      bad_ops = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
      rst = 1'b1;
      wp_n = 1'b1;
      strap = $random(seed);
      addr = {dual_pot_pkg::DEV_TYPE, strap};
      for (int i = 0; i < 8; i++) stored[i] = dual_pot_pkg::STORED_INIT;
      wiper[0] = stored[0];
      wiper[1] = stored[4];
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      repeat (10) @(posedge clk);
      compare_all();
      for (int p = 0; p < 2; p++) begin
         d = $random(seed);
         wr({dual_pot_pkg::OP_WR_WIPER, 3'h0, p[0]}, d, 1'b1);
         wiper[p] = d;
      end
      for (int i = 0; i < 8; i++) begin
         d = $random(seed);
         wr({dual_pot_pkg::OP_WR_STORED, i[1:0], 1'b0, i[2]}, d, 1'b1);
         stored[i] = d;
         prog_wait();
      end
      compare_all();
      for (int b = 0; b < 2; b++) begin
         master_u.start_c();
         master_u.xfer(addr ^ (b ? 8'h08 : 8'h10), 1'b1, q, d[0]);
         chk("foreign ack", 8'h00, {7'h0, d[0]});
         master_u.xfer({dual_pot_pkg::OP_WR_WIPER, 4'h0}, 1'b1, q, d[0]);
         master_u.xfer(8'h33, 1'b1, q, d[0]);
         master_u.stop_c();
      end
      k = $random(seed) & 3;
      cmd({dual_pot_pkg::OP_COPY_S2W, k[1:0], 2'h1});
      wiper[1] = stored[4 + k];
      cmd({dual_pot_pkg::OP_COPY_W2S, 2'h3 - k[1:0], 2'h0});
      stored[3 - k] = wiper[0];
      prog_wait();
      compare_all();
      cmd({dual_pot_pkg::OP_GANG_S2W, 2'h2, 2'h0});
      wiper[0] = stored[2];
      wiper[1] = stored[6];
      wr({dual_pot_pkg::OP_WR_WIPER, 4'h0}, 8'h11, 1'b1);
      wiper[0] = 8'h11;
      cmd({dual_pot_pkg::OP_GANG_W2S, 2'h1, 2'h0});
      stored[1] = wiper[0];
      stored[5] = wiper[1];
      prog_wait();
      compare_all();
      // Protected write: data refused, nothing programmed
      wp_n = 1'b0;
      wr({dual_pot_pkg::OP_WR_STORED, 4'h5}, 8'hA5, 1'b0);
      wp_n = 1'b1;
      step_run(1'b1, 8'hFD, 4, 1);
      step_run(1'b0, 8'h02, 0, 4);
      for (int i = 0; i < 7; i++) begin
         d = $random(seed);
         cmd({bad_ops[i], d[3:0]});
      end
      cmd({dual_pot_pkg::OP_WR_WIPER, 4'h4});
      compare_all();
      summarize();
   end
endmodule
